// ===== bench/psv_core_test.sv
// self-checking testbench for the program space and vectoring core
`timescale 1ns/1ps
module psv_core_test;
   import psv_pkg::*;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   localparam logic [PC_W-1:0] LIMIT = PC_W'(FLASH_BYTES_SMALL);
   logic clk = 1'b0, reset_n = 1'b0, step = 1'b0, wake_irq = 1'b0, irq_high = 1'b0;
   logic [13:0] flash_addr;
   logic [15:0] flash_rdata, instr_word;
   logic [20:0] program_counter;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [1:0] exp_b[$];
   logic [33:0] exp_r[$];
   int n_errors = 0, n_checks = 0;
   int rn;
   logic [20:0] p;

   initial forever #4 clk = ~clk;

   psv_core #(.LARGE_VARIANT(1'b0)) dut (.clk(clk), .reset_n(reset_n), .step(step), .wake_irq(wake_irq),
      .irq_high(irq_high), .flash_addr(flash_addr), .flash_rdata(flash_rdata), .instr_word(instr_word),
      .program_counter(program_counter), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   psv_flash_model flash (.flash_addr(flash_addr), .flash_rdata(flash_rdata));

   // ---------------------------------------------------------------
   // checking
   // ---------------------------------------------------------------
   task automatic fail(input string msg);
      $display("ERROR %0t %s", $time, msg);
      n_errors++;
   endtask
   task automatic chk_rd(input logic [33:0] got, input logic [33:0] exp);
      n_checks++;
      if (got !== exp) fail($sformatf("read got %h exp %h", got, exp));
   endtask
   task automatic chk_b(input logic [1:0] got, input logic [1:0] exp);
      n_checks++;
      if (got !== exp) fail($sformatf("bresp got %h exp %h", got, exp));
   endtask
   task automatic chk_core(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) fail($sformatf("core got %h exp %h", got, exp));
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // monitor: each bus answer takes the oldest note
   always @(posedge clk) begin
      if (rvalid && rready) begin
         if (exp_r.size() == 0) fail("unexpected read data");
         else chk_rd({rresp, rdata}, exp_r.pop_front());
      end
      if (bvalid && bready) begin
         if (exp_b.size() == 0) fail("unexpected write response");
         else chk_b(bresp, exp_b.pop_front());
      end
   end

   // ---------------------------------------------------------------
   // drivers
   // ---------------------------------------------------------------
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk);
      exp_b.push_back(r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bready && bvalid) bready <= 1'b0;
      end while ((awvalid || wvalid || bready) && n < 50);
      if (n >= 50) begin
         fail("write timeout");
         test_done;
      end
   endtask
   task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk);
      exp_r.push_back({r, d});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
         if (rready && rvalid) rready <= 1'b0;
      end while ((arvalid || rready) && n < 50);
      if (n >= 50) begin
         fail("read timeout");
         test_done;
      end
   endtask
   task automatic step_n(input int n);
      @(posedge clk);
      step <= 1'b1;
      repeat (n) @(posedge clk);
      step <= 1'b0;
   endtask
   task automatic wake(input logic h);
      @(posedge clk);
      wake_irq <= 1'b1;
      irq_high <= h;
      @(posedge clk);
      wake_irq <= 1'b0;
      @(posedge clk);
   endtask
   // pc and the registered fetch word once the pipeline has settled
   task automatic chk_fetch(input logic [20:0] ep);
      repeat (2) @(posedge clk);
      chk_core({11'h000, program_counter}, {11'h000, ep});
      chk_core({16'h0000, instr_word}, {16'h0000, (ep < LIMIT) ? {2'b10, ep[14:1]} : NOP_WORD});
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(51549));
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      chk_fetch(RESET_VECTOR);
      axi_read(SP_OFFSET, 32'h0, RESP_OKAY);
      axi_read(TOS_OFFSET, 32'h0, RESP_OKAY);
      rn = $urandom_range(20, 1);
      step_n(rn);
      chk_fetch(21'(2 * rn));
      fork
         step_n(5);
         axi_read(CTRL_OFFSET, 32'h0, RESP_OKAY);
      join
      p = 21'(2 * rn + 10);
      chk_fetch(p);
      axi_write(CTRL_OFFSET, 32'h5, RESP_OKAY);
      step_n(2);
      chk_fetch(p);
      wake(1'b1);
      chk_fetch(HIGH_VECTOR);
      axi_read(SP_OFFSET, 32'h1, RESP_OKAY);
      axi_read(TOS_OFFSET, {11'h000, p}, RESP_OKAY);
      axi_read(FLAGS_OFFSET, 32'h1, RESP_OKAY);
      step_n(3);
      axi_write(CTRL_OFFSET, 32'h6, RESP_OKAY);
      wake(1'b0);
      chk_fetch(LOW_VECTOR);
      axi_read(SP_OFFSET, 32'h2, RESP_OKAY);
      axi_read(TOS_OFFSET, 32'h0000000E, RESP_OKAY);
      axi_read(FLAGS_OFFSET, 32'h3, RESP_OKAY);
      axi_write(FLAGS_OFFSET, 32'h3, RESP_OKAY);
      axi_read(FLAGS_OFFSET, 32'h0, RESP_OKAY);
      axi_write(CTRL_OFFSET, 32'h4, RESP_OKAY);
      wake(1'b1);
      chk_fetch(LOW_VECTOR + PC_STEP);
      axi_read(SP_OFFSET, 32'h2, RESP_OKAY);
      axi_read(FLAGS_OFFSET, 32'h1, RESP_OKAY);
      axi_write(8'h40, 32'hFFFFFFFF, RESP_DECERR);
      axi_read(8'h40, 32'h0, RESP_DECERR);
      axi_write(PC_OFFSET, 32'h000000FF, RESP_OKAY);
      axi_read(PC_OFFSET, 32'h0000001A, RESP_OKAY);
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      chk_fetch(RESET_VECTOR);
      axi_read(SP_OFFSET, 32'h0, RESP_OKAY);
      axi_read(CTRL_OFFSET, 32'h0, RESP_OKAY);
      // low byte lane off: the write must leave control untouched
      wstrb <= 4'hE;
      axi_write(CTRL_OFFSET, 32'h7, RESP_OKAY);
      wstrb <= 4'hF;
      axi_read(CTRL_OFFSET, 32'h0, RESP_OKAY);
      step_n(8191);
      chk_fetch(21'h03FFE);
      step_n(1);
      chk_fetch(LIMIT);
      // fill the stack: 31 pushes, then one more that must not push but still vector
      for (int i = 0; i < 32; i++) begin
         axi_write(CTRL_OFFSET, 32'h5, RESP_OKAY);
         wake(1'b1);
      end
      chk_fetch(HIGH_VECTOR);
      axi_read(SP_OFFSET, 32'h0000009F, RESP_OKAY);
      axi_write(SP_OFFSET, 32'h00000080, RESP_OKAY);
      axi_read(SP_OFFSET, 32'h0000001F, RESP_OKAY);
      test_done;
   end
endmodule

// ===== bench/psv_flash_model.sv
// program flash partner model: combinational word read, every word non-zero
`timescale 1ns/1ps
module psv_flash_model (
   input wire logic [13:0] flash_addr,
   output logic [15:0] flash_rdata
);
   // instruction port of its own, apart from the register bus
   assign flash_rdata = {2'b10, flash_addr};
endmodule

// ===== shared/psv_pkg.sv
// package: program space and vectoring constants, register map and field layouts
package psv_pkg;
   // ---------------------------------------------------------------
   // program space
   // ---------------------------------------------------------------
   localparam int PC_W = 21;
   localparam int SP_W = 5;
   localparam int STACK_DEPTH = 31;
   localparam int INSTR_W = 16;
   localparam int FLASH_ADDR_W = 14;
   localparam int FLASH_BYTES_SMALL = 16384;
   localparam int FLASH_BYTES_LARGE = 32768;
   localparam int FLASH_WORDS_SMALL = 8192;
   localparam int FLASH_WORDS_LARGE = 16384;
   localparam logic [PC_W-1:0] PC_STEP = 21'h00002;
   localparam logic [PC_W-1:0] RESET_VECTOR = 21'h00000;
   localparam logic [PC_W-1:0] HIGH_VECTOR = 21'h00008;
   localparam logic [PC_W-1:0] LOW_VECTOR = 21'h00018;
   localparam logic [SP_W-1:0] SP_RESET = 5'h00;
   localparam logic [SP_W-1:0] SP_MAX = 5'h1F;
   localparam logic [INSTR_W-1:0] NOP_WORD = 16'h0000;

   // ---------------------------------------------------------------
   // register map (byte addresses) and fields
   // ---------------------------------------------------------------
   localparam int AXI_ADDR_W = 8;
   localparam logic [AXI_ADDR_W-1:0] CTRL_OFFSET = 8'h00;
   localparam logic [AXI_ADDR_W-1:0] PC_OFFSET = 8'h04;
   localparam logic [AXI_ADDR_W-1:0] SP_OFFSET = 8'h08;
   localparam logic [AXI_ADDR_W-1:0] TOS_OFFSET = 8'h0C;
   localparam logic [AXI_ADDR_W-1:0] FLAGS_OFFSET = 8'h10;
   localparam int CTRL_HIGH_EN_BIT = 0;
   localparam int CTRL_LOW_EN_BIT = 1;
   localparam int CTRL_SLEEP_BIT = 2;
   localparam int SP_FULL_BIT = 7;
   localparam int FLAG_HIGH_BIT = 0;
   localparam int FLAG_LOW_BIT = 1;
   localparam int TOS_LOW_LSB = 0;
   localparam int TOS_HIGH_LSB = 8;
   localparam int TOS_UPPER_LSB = 16;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// ===== src/psv_core.sv
// program counter, fetch gating, reset and interrupt vectoring, with register slave
//
// Overview of operation
// [R1] program counter is 21 bits and spans a 2-Mbyte byte-addressed space
// [R2] fetches above the implemented flash return an all-zero word, a no-op
// [R3] instruction fetch port is separate from the register/data bus
// [R4] every reset loads the program counter with 0000h
// [R5] only two interrupt entries exist, 0008h and 0018h
// [R6] implemented flash is 16 Kbytes small, 32 Kbytes large variant
// [R7] enabled interrupt wake-up saves the program counter on top of stack; with the stack pointer at SP_MAX the code skips the save
// [R8] enabled interrupt wake-up advances the stack pointer to a new entry; at SP_MAX the code holds it there
// [R9] after saving, the program counter is loaded with the interrupt vector
// [R10] interrupt wake-up sets a flag bit naming its source, others unchanged
// [R11] high priority uses 0008h, low priority uses 0018h
// [R12] program counter steps by two, least significant bit stays zero
// [R13] push increments the stack pointer, then writes that entry
// [R14] stack pointer resets to zero, zero location has no storage
// [R15] wake-up with both enables clear: no push, no vector, continue after sleep
`timescale 1ns/1ps
module psv_core
   import psv_pkg::*;
#(
   parameter bit LARGE_VARIANT = 1'b1
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic step,
   input wire logic wake_irq,
   input wire logic irq_high,
   output logic [psv_pkg::FLASH_ADDR_W-1:0] flash_addr,
   input wire logic [psv_pkg::INSTR_W-1:0] flash_rdata,
   output logic [psv_pkg::INSTR_W-1:0] instr_word,
   output logic [psv_pkg::PC_W-1:0] program_counter,
   input wire logic [psv_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [psv_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import psv_pkg::*;

   localparam int FLASH_BYTES = LARGE_VARIANT ? FLASH_BYTES_LARGE : FLASH_BYTES_SMALL;
   localparam logic [PC_W-1:0] FLASH_LIMIT = PC_W'(FLASH_BYTES);

   logic [PC_W-1:0] pc;
   logic [SP_W-1:0] return_stack_pointer;
   logic stack_full;
   logic high_priority_global_enable;
   logic low_priority_global_enable;
   logic sleeping;
   logic [1:0] peripheral_request_flags;
   logic [PC_W-1:0] top_of_stack;
   logic wake;
   logic wake_take;
   logic do_push;
   logic [SP_W-1:0] next_sp;
   logic aw_held;
   logic w_held;
   logic [AXI_ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic w_strb0;
   logic wr_fire;
   logic wr_ctrl;
   logic wr_sp;
   logic wr_flags;
   logic wr_mapped;
   logic [31:0] rd_mux;
   logic rd_mapped;

   // ---------------------------------------------------------------
   // wake-up decode
   // ---------------------------------------------------------------
   assign wake = wake_irq && sleeping;
   assign wake_take = wake && (high_priority_global_enable || low_priority_global_enable); // R7 R15
   assign do_push = wake_take && return_stack_pointer != SP_MAX;
   assign next_sp = return_stack_pointer + 5'h01; // R13

   // ---------------------------------------------------------------
   // program counter
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pc <= RESET_VECTOR; // R4
      end else if (wake_take) begin
         pc <= irq_high ? HIGH_VECTOR : LOW_VECTOR; // R5 R9 R11
      end else if (wake) begin
         pc <= pc + PC_STEP; // R15
      end else if (step && !sleeping) begin
         pc <= (pc + PC_STEP) & ~PC_W'(1); // R1 R12
      end
   end

   assign program_counter = pc;
   assign flash_addr = pc[FLASH_ADDR_W:1]; // R3

   // fetch gate: beyond implemented flash reads as a no-op
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         instr_word <= NOP_WORD;
      end else if (pc < FLASH_LIMIT) begin
         instr_word <= flash_rdata; // R6
      end else begin
         instr_word <= NOP_WORD; // R2
      end
   end

   // ---------------------------------------------------------------
   // return stack pointer and full flag
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         return_stack_pointer <= SP_RESET; // R14
      end else if (do_push) begin
         return_stack_pointer <= next_sp; // R8 R13
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stack_full <= 1'b0;
      end else if (do_push && next_sp == SP_MAX) begin
         stack_full <= 1'b1;
      end else if (wr_sp && w_data[SP_FULL_BIT]) begin
         stack_full <= 1'b0;
      end
   end

   psv_return_stack #(
      .DEPTH(STACK_DEPTH),
      .WIDTH(PC_W)
   ) u_stack (
      .clk(clk),
      .push(do_push), // R7
      .wr_ptr(next_sp),
      .wr_data(pc),
      .rd_ptr(return_stack_pointer),
      .top_of_stack(top_of_stack)
   );

   // ---------------------------------------------------------------
   // control bits and wake source flags
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         high_priority_global_enable <= 1'b0;
         low_priority_global_enable <= 1'b0;
      end else if (wr_ctrl) begin
         high_priority_global_enable <= w_data[CTRL_HIGH_EN_BIT];
         low_priority_global_enable <= w_data[CTRL_LOW_EN_BIT];
      end
   end

   // wake clears sleep and beats a simultaneous write
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sleeping <= 1'b0;
      end else if (wake) begin
         sleeping <= 1'b0;
      end else if (wr_ctrl) begin
         sleeping <= w_data[CTRL_SLEEP_BIT];
      end
   end

   // write one to clear, hardware set wins
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         peripheral_request_flags <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (wake && (irq_high ? (i == FLAG_HIGH_BIT) : (i == FLAG_LOW_BIT))) begin
               peripheral_request_flags[i] <= 1'b1; // R10
            end else if (wr_flags && w_data[i]) begin
               peripheral_request_flags[i] <= 1'b0;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // register slave, write side
   // ---------------------------------------------------------------
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign wr_ctrl = wr_fire && w_strb0 && aw_addr == CTRL_OFFSET;
   assign wr_sp = wr_fire && w_strb0 && aw_addr == SP_OFFSET;
   assign wr_flags = wr_fire && w_strb0 && aw_addr == FLAGS_OFFSET;
   assign wr_mapped = aw_addr == CTRL_OFFSET || aw_addr == PC_OFFSET || aw_addr == SP_OFFSET
      || aw_addr == TOS_OFFSET || aw_addr == FLAGS_OFFSET;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= {s_axi_awaddr[AXI_ADDR_W-1:2], 2'h0};
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb0 <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb0 <= s_axi_wstrb[0];
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // register slave, read side
   // ---------------------------------------------------------------
   always_comb begin
      rd_mux = '0;
      rd_mapped = 1'b1;
      if ({s_axi_araddr[AXI_ADDR_W-1:2], 2'h0} == CTRL_OFFSET) begin
         rd_mux[CTRL_HIGH_EN_BIT] = high_priority_global_enable;
         rd_mux[CTRL_LOW_EN_BIT] = low_priority_global_enable;
         rd_mux[CTRL_SLEEP_BIT] = sleeping;
      end else if ({s_axi_araddr[AXI_ADDR_W-1:2], 2'h0} == PC_OFFSET) begin
         rd_mux[PC_W-1:0] = pc;
      end else if ({s_axi_araddr[AXI_ADDR_W-1:2], 2'h0} == SP_OFFSET) begin
         rd_mux[SP_W-1:0] = return_stack_pointer;
         rd_mux[SP_FULL_BIT] = stack_full;
      end else if ({s_axi_araddr[AXI_ADDR_W-1:2], 2'h0} == TOS_OFFSET) begin
         rd_mux[TOS_LOW_LSB +: 8] = top_of_stack[7:0];
         rd_mux[TOS_HIGH_LSB +: 8] = top_of_stack[15:8];
         rd_mux[TOS_UPPER_LSB +: 5] = top_of_stack[20:16];
      end else if ({s_axi_araddr[AXI_ADDR_W-1:2], 2'h0} == FLAGS_OFFSET) begin
         rd_mux[1:0] = peripheral_request_flags;
      end else begin
         rd_mapped = 1'b0;
      end
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_reset_vector;
      @(posedge clk) $rose(reset_n) |-> pc == RESET_VECTOR && return_stack_pointer == SP_RESET;
   endproperty
   a_reset_vector: assert property (p_reset_vector) else $error("pc or sp not zero after reset"); // R4 R14

   property p_pc_aligned;
      @(posedge clk) disable iff (!reset_n) pc[0] == 1'b0;
   endproperty
   a_pc_aligned: assert property (p_pc_aligned) else $error("pc misaligned"); // R12

   property p_pc_step;
      @(posedge clk) disable iff (!reset_n) step && !sleeping |=> pc == $past(pc) + PC_STEP;
   endproperty
   a_pc_step: assert property (p_pc_step) else $error("pc did not step by two"); // R12 R1

   property p_beyond_flash;
      @(posedge clk) disable iff (!reset_n) pc >= FLASH_LIMIT |=> instr_word == NOP_WORD;
   endproperty
   a_beyond_flash: assert property (p_beyond_flash) else $error("fetch beyond flash not zero"); // R2

   property p_inside_flash;
      @(posedge clk) disable iff (!reset_n) pc < FLASH_LIMIT |=> instr_word == $past(flash_rdata);
   endproperty
   a_inside_flash: assert property (p_inside_flash) else $error("fetch inside flash lost data"); // R6

   property p_fetch_port;
      @(posedge clk) disable iff (!reset_n)
         (s_axi_arvalid || wr_fire) && step && !sleeping |=> pc == $past(pc) + PC_STEP;
   endproperty
   a_fetch_port: assert property (p_fetch_port) else $error("fetch stalled by bus access"); // R3

   property p_vector;
      @(posedge clk) disable iff (!reset_n)
         wake_take |=> pc == ($past(irq_high) ? HIGH_VECTOR : LOW_VECTOR) && !sleeping;
   endproperty
   a_vector: assert property (p_vector) else $error("wrong interrupt vector"); // R5 R9 R11

   property p_push;
      @(posedge clk) disable iff (!reset_n)
         do_push |=> return_stack_pointer == $past(next_sp) && top_of_stack == $past(pc);
   endproperty
   a_push: assert property (p_push) else $error("push did not save pc on new entry"); // R7 R8 R13

   property p_no_enable;
      @(posedge clk) disable iff (!reset_n) wake && !wake_take
         |=> pc == $past(pc) + PC_STEP && $stable(return_stack_pointer);
   endproperty
   a_no_enable: assert property (p_no_enable) else $error("disabled wake pushed or vectored"); // R15

   property p_wake_flag;
      @(posedge clk) disable iff (!reset_n)
         wake |=> peripheral_request_flags[$past(irq_high) ? FLAG_HIGH_BIT : FLAG_LOW_BIT];
   endproperty
   a_wake_flag: assert property (p_wake_flag) else $error("wake source flag not set"); // R10

   c_wake_high: cover property (@(posedge clk) disable iff (!reset_n) wake_take && irq_high);
   c_wake_low: cover property (@(posedge clk) disable iff (!reset_n) wake_take && !irq_high);
   c_wake_disabled: cover property (@(posedge clk) disable iff (!reset_n) wake && !wake_take);
   c_beyond: cover property (@(posedge clk) disable iff (!reset_n) step && pc == FLASH_LIMIT - PC_STEP);
endmodule

// ===== src/psv_return_stack.sv
// return address stack: 31 entries, location zero has no storage
`timescale 1ns/1ps
module psv_return_stack #(
   parameter int DEPTH = 31,
   parameter int WIDTH = 21
) (
   input wire logic clk,
   input wire logic push,
   input wire logic [4:0] wr_ptr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [4:0] rd_ptr,
   output logic [WIDTH-1:0] top_of_stack
);
   logic [WIDTH-1:0] mem [1:DEPTH];

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (push && wr_ptr != 5'h00) begin
         mem[wr_ptr] <= wr_data;
      end
   end

   // pointer zero reads as zero
   always_comb begin
      if (rd_ptr == 5'h00) begin
         top_of_stack = '0;
      end else begin
         top_of_stack = mem[rd_ptr];
      end
   end
endmodule
